// ==== include/adclp_pkg.sv ====
// adclp_pkg: register map, field positions, states and timing constants of the converter control block.
// assumes a 32-bit classic wishbone slave with one aligned word per register, 8-bit data in the low bits.
package adclp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS_CONTROL_ONE     = 8'h00;
    localparam logic [7:0] ADDR_STATUS_CONTROL_TWO     = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH_BYTE       = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW_BYTE        = 8'h0C;
    localparam logic [7:0] ADDR_COMPARE_VALUE_HIGH     = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_VALUE_LOW      = 8'h14;
    localparam logic [7:0] ADDR_CONVERTER_CONFIGURATION = 8'h18;
    localparam logic [7:0] ADDR_PIN_CONTROL_FIRST      = 8'h1C;
    localparam logic [7:0] ADDR_PIN_CONTROL_SECOND     = 8'h20;

    // reset values
    localparam logic [7:0] RST_STATUS_CONTROL_ONE = 8'h1F;
    localparam logic [7:0] RST_ZERO_BYTE          = 8'h00;
    localparam logic [4:0] CHANNEL_ALL_ONES       = 5'h1F;

    // field encodings
    localparam logic [1:0] MODE_8BIT        = 2'h0;
    localparam logic [1:0] MODE_12BIT       = 2'h1;
    localparam logic [1:0] MODE_10BIT       = 2'h2;
    localparam logic [1:0] CLKSRC_BUS       = 2'h0;
    localparam logic [1:0] CLKSRC_BUS_HALF  = 2'h1;
    localparam logic [1:0] CLKSRC_ALT       = 2'h2;
    localparam logic [1:0] CLKSRC_ASYNC     = 2'h3;

    // conversion lengths in conversion clock cycles
    localparam logic [5:0] SAMPLE_SHORT_CYC = 6'h03;
    localparam logic [5:0] SAMPLE_LONG_CYC  = 6'h17;
    localparam logic [5:0] SAR_8BIT_CYC     = 6'h11;
    localparam logic [5:0] SAR_WIDE_CYC     = 6'h14;
    // async generator division of the local oscillator tick
    localparam logic [1:0] ASYNC_DIV        = 2'h1;

    typedef struct packed {
        logic       low_power_select;
        logic [1:0] clock_divider;
        logic       long_sample_select;
        logic [1:0] mode;
        logic [1:0] input_clock_source;
    } adclp_cfg_type;

    typedef struct packed {
        logic       trigger_select;
        logic       compare_enable;
        logic       compare_greater_select;
    } adclp_sc2_type;

    typedef struct packed {
        logic       completion_irq_enable;
        logic       continuous_enable;
        logic [4:0] channel_select;
    } adclp_sc1_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } adclp_state_type;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_STOP3 = 2'b01,
        PWR_STOP12 = 2'b10
    } adclp_power_type;
endpackage

// ==== src/adclp_control.sv ====
// adclp_control: converter sequencing, result/compare registers, low-power mode handling, wishbone slave.
// assumes analog sample is on analog_result_i two cycles before conv_done; all inputs on clk_i except stop3_i, stop12_i, hw_trigger_i and analog_result_i.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adclp_control #(
    parameter int RES_W = 12
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  wb_err_o,
    input  wire logic             hw_trigger_i,
    input  wire logic             stop3_i,
    input  wire logic             stop12_i,
    input  wire logic [RES_W-1:0] analog_result_i,
    output logic      [4:0]       channel_select_o,
    output logic      [15:0]      pin_io_disable_o,
    output logic                  sample_o,
    output logic                  irq_o
);
    // low-power request, trigger and analog word come from other domains
    logic        stop3_meta, stop3_sync, stop12_meta, stop12_sync, trig_meta, trig_sync, trig_prev;
    logic [RES_W-1:0] ana_meta, ana_sync;
    always_ff @(posedge clk_i) begin
        stop3_meta  <= stop3_i;
        stop3_sync  <= stop3_meta;
        stop12_meta <= stop12_i;
        stop12_sync <= stop12_meta;
        trig_meta   <= hw_trigger_i;
        trig_sync   <= trig_meta;
        trig_prev   <= trig_sync;
        ana_meta    <= analog_result_i;
        ana_sync    <= ana_meta;
    end

    adclp_pkg::adclp_cfg_type   cfg_reg;
    adclp_pkg::adclp_sc2_type   sc2_reg;
    adclp_pkg::adclp_sc1_type   sc1_reg;
    adclp_pkg::adclp_state_type state_reg;
    adclp_pkg::adclp_power_type power_reg;
    logic [7:0]  pin1_reg, pin2_reg, cv_high_reg, cv_low_reg;
    logic [15:0] result_reg;
    logic        complete_reg, blocked_reg, pending_reg;
    logic [5:0]  phase_cnt_reg;
    logic [1:0]  async_cnt_reg;
    logic        tick;
    logic        async_sel, stop3_gated;

    // wishbone decode
    logic wb_req, wr_en, rd_ok, ack_reg, err_reg;
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == adclp_pkg::ADDR_STATUS_CONTROL_ONE) || (a == adclp_pkg::ADDR_STATUS_CONTROL_TWO) ||
                     (a == adclp_pkg::ADDR_RESULT_HIGH_BYTE) || (a == adclp_pkg::ADDR_RESULT_LOW_BYTE) ||
                     (a == adclp_pkg::ADDR_COMPARE_VALUE_HIGH) || (a == adclp_pkg::ADDR_COMPARE_VALUE_LOW) ||
                     (a == adclp_pkg::ADDR_CONVERTER_CONFIGURATION) ||
                     (a == adclp_pkg::ADDR_PIN_CONTROL_FIRST) || (a == adclp_pkg::ADDR_PIN_CONTROL_SECOND);
    endfunction
    assign rd_ok = known_addr(wb_adr_i);
    assign wr_en = wb_req & wb_we_i & wb_sel_i[0] & rd_ok;

    function automatic logic wr_at(input logic [7:0] a, input logic [7:0] target, input logic en);
        wr_at = en && (a == target);
    endfunction

    logic wr_sc1, wr_other_cfg, rd_high, rd_low;
    assign wr_sc1       = wr_at(wb_adr_i, adclp_pkg::ADDR_STATUS_CONTROL_ONE, wr_en);
    assign wr_other_cfg = wr_at(wb_adr_i, adclp_pkg::ADDR_STATUS_CONTROL_TWO, wr_en) |
                          wr_at(wb_adr_i, adclp_pkg::ADDR_CONVERTER_CONFIGURATION, wr_en) |
                          wr_at(wb_adr_i, adclp_pkg::ADDR_COMPARE_VALUE_HIGH, wr_en) |
                          wr_at(wb_adr_i, adclp_pkg::ADDR_COMPARE_VALUE_LOW, wr_en);
    assign rd_high = wr_at(wb_adr_i, adclp_pkg::ADDR_RESULT_HIGH_BYTE, wb_req & ~wb_we_i);
    assign rd_low  = wr_at(wb_adr_i, adclp_pkg::ADDR_RESULT_LOW_BYTE, wb_req & ~wb_we_i);

    // power mode tracking
    logic pwr_reset;
    assign pwr_reset = rst_i | stop12_sync;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_reg <= adclp_pkg::PWR_RUN;
        end else if (stop12_sync) begin
            power_reg <= adclp_pkg::PWR_STOP12;
        end else if (stop3_sync) begin
            power_reg <= adclp_pkg::PWR_STOP3;
        end else begin
            power_reg <= adclp_pkg::PWR_RUN;
        end
    end

    assign async_sel   = (cfg_reg.input_clock_source == adclp_pkg::CLKSRC_ASYNC);
    // bus clock sources are gated off in stop3; only the local async generator keeps ticking
    assign stop3_gated = (power_reg == adclp_pkg::PWR_STOP3) & ~async_sel;

    // registers; stop1/stop2 forces every register to reset
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            cfg_reg     <= '0;
            sc2_reg     <= '0;
            sc1_reg     <= adclp_pkg::adclp_sc1_type'(adclp_pkg::RST_STATUS_CONTROL_ONE[6:0]);
            pin1_reg    <= adclp_pkg::RST_ZERO_BYTE;
            pin2_reg    <= adclp_pkg::RST_ZERO_BYTE;
            cv_high_reg <= adclp_pkg::RST_ZERO_BYTE;
            cv_low_reg  <= adclp_pkg::RST_ZERO_BYTE;
        end else if (wr_en) begin
            case (wb_adr_i)
                adclp_pkg::ADDR_CONVERTER_CONFIGURATION: cfg_reg <= wb_dat_i[7:0];
                adclp_pkg::ADDR_STATUS_CONTROL_TWO:      sc2_reg <= wb_dat_i[6:4];
                adclp_pkg::ADDR_STATUS_CONTROL_ONE:      sc1_reg <= wb_dat_i[6:0];
                adclp_pkg::ADDR_COMPARE_VALUE_HIGH:      cv_high_reg <= wb_dat_i[7:0];
                adclp_pkg::ADDR_COMPARE_VALUE_LOW:       cv_low_reg  <= wb_dat_i[7:0];
                adclp_pkg::ADDR_PIN_CONTROL_FIRST:       pin1_reg <= wb_dat_i[7:0];
                adclp_pkg::ADDR_PIN_CONTROL_SECOND:      pin2_reg <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // conversion clock tick: local async generator or divided bus clock
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            async_cnt_reg <= '0;
        end else if (async_sel) begin
            async_cnt_reg <= (async_cnt_reg == adclp_pkg::ASYNC_DIV) ? 2'h0 : 2'(async_cnt_reg + 2'h1);
        end
    end
    logic [3:0] div_limit;
    always_comb begin
        // divider 00 gives one tick every input clock
        div_limit = 4'(({2'h0, 2'h1} << cfg_reg.clock_divider) - 4'h1);
        if (cfg_reg.input_clock_source == adclp_pkg::CLKSRC_BUS_HALF) begin
            div_limit = 4'({div_limit, 1'b1});
        end
    end
    logic [3:0] div_full_reg;
    always_ff @(posedge clk_i) begin
        if (pwr_reset || state_reg == adclp_pkg::ST_IDLE) begin
            div_full_reg <= '0;
        end else begin
            div_full_reg <= (div_full_reg >= div_limit) ? 4'h0 : 4'(div_full_reg + 4'h1);
        end
    end
    assign tick = async_sel ? (async_cnt_reg == adclp_pkg::ASYNC_DIV) && (div_full_reg >= div_limit)
                            : (div_full_reg >= div_limit) && !stop3_sync;

    // conversion sequencing
    logic start_req, conv_done, abort, wide_mode, sw_start, hw_start, cmp_true, transfer;
    logic [15:0] raw_res, cmp_val, diff_res;
    assign wide_mode = (cfg_reg.mode == adclp_pkg::MODE_10BIT) || (cfg_reg.mode == adclp_pkg::MODE_12BIT);
    assign sw_start  = wr_sc1 && (wb_dat_i[4:0] != adclp_pkg::CHANNEL_ALL_ONES) && !wb_dat_i[5] ? 1'b1
                     : wr_sc1 && (wb_dat_i[4:0] != adclp_pkg::CHANNEL_ALL_ONES);
    assign hw_start  = sc2_reg.trigger_select && trig_sync && !trig_prev;
    // stop3 without async clock: abort, then wait for a fresh trigger
    assign abort     = wr_sc1 | wr_other_cfg | stop3_gated;
    // a control-one write aborts; one with a channel other than all ones restarts at once, unless hardware triggers are selected or stop3 gates the clock
    logic       restart;
    logic [5:0] sample_len;
    assign restart    = sw_start && !sc2_reg.trigger_select && !stop3_gated;
    assign sample_len = cfg_reg.long_sample_select ? adclp_pkg::SAMPLE_LONG_CYC : adclp_pkg::SAMPLE_SHORT_CYC;
    assign start_req = (sc2_reg.trigger_select ? hw_start : sw_start) | pending_reg;

    function automatic logic [15:0] scale(input logic [RES_W-1:0] v, input logic [1:0] m);
        case (m)
            adclp_pkg::MODE_8BIT:  scale = 16'(v[RES_W-1 -: 8]);
            adclp_pkg::MODE_10BIT: scale = 16'(v[RES_W-1 -: 10]);
            default:               scale = 16'(v);
        endcase
    endfunction
    assign raw_res  = scale(ana_sync, cfg_reg.mode);
    assign cmp_val  = {cv_high_reg, cv_low_reg};
    assign diff_res = 16'(raw_res + (~cmp_val + 16'h0001));
    // greater select: result >= limit; otherwise result < limit
    assign cmp_true = sc2_reg.compare_greater_select ? (raw_res >= cmp_val) : (raw_res < cmp_val);

    always_ff @(posedge clk_i) begin
        if (pwr_reset || (abort && !restart)) begin
            state_reg     <= adclp_pkg::ST_IDLE;
            phase_cnt_reg <= '0;
        end else if (restart) begin
            state_reg     <= adclp_pkg::ST_SAMPLE;
            phase_cnt_reg <= sample_len;
        end else begin
            case (state_reg)
                adclp_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state_reg     <= adclp_pkg::ST_SAMPLE;
                        phase_cnt_reg <= sample_len;
                    end
                end
                adclp_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (phase_cnt_reg == '0) begin
                            state_reg     <= adclp_pkg::ST_CONVERT;
                            phase_cnt_reg <= wide_mode ? adclp_pkg::SAR_WIDE_CYC : adclp_pkg::SAR_8BIT_CYC;
                        end else begin
                            phase_cnt_reg <= 6'(phase_cnt_reg - 6'h01);
                        end
                    end
                end
                adclp_pkg::ST_CONVERT: begin
                    if (tick) begin
                        if (phase_cnt_reg == '0) begin
                            state_reg <= adclp_pkg::ST_IDLE;
                        end else begin
                            phase_cnt_reg <= 6'(phase_cnt_reg - 6'h01);
                        end
                    end
                end
                default: state_reg <= adclp_pkg::ST_IDLE;
            endcase
        end
    end
    assign conv_done = (state_reg == adclp_pkg::ST_CONVERT) && tick && (phase_cnt_reg == '0) && !abort;
    logic active_flag;
    assign active_flag = (state_reg != adclp_pkg::ST_IDLE);
    assign transfer  = conv_done && !blocked_reg && (!sc2_reg.compare_enable || cmp_true);

    // restart: continuous mode, or a blocked conversion that must be redone
    always_ff @(posedge clk_i) begin
        if (pwr_reset || abort) begin
            pending_reg <= 1'b0;
        end else if (conv_done) begin
            pending_reg <= sc1_reg.continuous_enable ||
                           (blocked_reg && !(sc2_reg.compare_enable && !cmp_true));
        end else if (state_reg == adclp_pkg::ST_IDLE) begin
            pending_reg <= 1'b0;
        end
    end

    // read-sequence lock: a high read in 10/12-bit mode opens it, low read closes it
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            blocked_reg <= 1'b0;
        end else if (rd_low) begin
            blocked_reg <= 1'b0;
        end else if (rd_high && wide_mode) begin
            blocked_reg <= 1'b1;
        end
    end

    // results survive stop3 and aborts; only reset or stop1/stop2 clears them
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            result_reg <= '0;
        end else if (transfer) begin
            result_reg <= sc2_reg.compare_enable ? diff_res : raw_res;
        end
    end

    // completion flag: set wins over the clearing write or read
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            complete_reg <= 1'b0;
        end else if (transfer) begin
            complete_reg <= 1'b1;
        end else if (wr_sc1 || rd_low || (rd_high && !wide_mode)) begin
            complete_reg <= 1'b0;
        end
    end

    // bus answer
    logic [7:0] rd_byte;
    always_comb begin
        case (wb_adr_i)
            adclp_pkg::ADDR_STATUS_CONTROL_ONE:      rd_byte = {complete_reg, sc1_reg};
            adclp_pkg::ADDR_STATUS_CONTROL_TWO:      rd_byte = {active_flag, sc2_reg, 4'h0};
            adclp_pkg::ADDR_RESULT_HIGH_BYTE:        rd_byte = result_reg[15:8];
            adclp_pkg::ADDR_RESULT_LOW_BYTE:         rd_byte = result_reg[7:0];
            adclp_pkg::ADDR_COMPARE_VALUE_HIGH:      rd_byte = cv_high_reg;
            adclp_pkg::ADDR_COMPARE_VALUE_LOW:       rd_byte = cv_low_reg;
            adclp_pkg::ADDR_CONVERTER_CONFIGURATION: rd_byte = cfg_reg;
            adclp_pkg::ADDR_PIN_CONTROL_FIRST:       rd_byte = pin1_reg;
            adclp_pkg::ADDR_PIN_CONTROL_SECOND:      rd_byte = pin2_reg;
            default:                                 rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            err_reg  <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_reg  <= wb_req & rd_ok;
            err_reg  <= wb_req & ~rd_ok;
            wb_dat_o <= (wb_req & rd_ok & ~wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;

    // outputs; interrupt wakes the core in stop3 as well
    always_ff @(posedge clk_i) begin
        if (pwr_reset) begin
            irq_o            <= 1'b0;
            sample_o         <= 1'b0;
            channel_select_o <= adclp_pkg::CHANNEL_ALL_ONES;
            pin_io_disable_o <= '0;
        end else begin
            irq_o            <= (transfer | complete_reg) & sc1_reg.completion_irq_enable;
            sample_o         <= (state_reg == adclp_pkg::ST_SAMPLE);
            channel_select_o <= sc1_reg.channel_select;
            pin_io_disable_o <= {pin2_reg, pin1_reg};
        end
    end

    // active flag spans start to conversion end or abort
    logic active_seen;
    assign active_seen = (state_reg != adclp_pkg::ST_IDLE);
    a_active_after_start: assert property (@(posedge clk_i) disable iff (pwr_reset)
        ((state_reg == adclp_pkg::ST_IDLE && start_req && !abort) || restart) |=> active_seen)
        else $error("active flag not set after start");
    a_stop3_abort_idle: assert property (@(posedge clk_i) disable iff (pwr_reset)
        stop3_gated |=> state_reg == adclp_pkg::ST_IDLE)
        else $error("stop3 without async clock did not idle");
    a_stop3_no_restart: assert property (@(posedge clk_i) disable iff (pwr_reset)
        (stop3_gated ##1 !stop3_gated && !start_req) |=> state_reg == adclp_pkg::ST_IDLE)
        else $error("converter resumed without a trigger");
    a_result_kept: assert property (@(posedge clk_i) disable iff (pwr_reset)
        !transfer |=> result_reg == $past(result_reg))
        else $error("result changed without transfer");
    a_block_discard: assert property (@(posedge clk_i) disable iff (pwr_reset)
        (conv_done && blocked_reg && !rd_low) |=> !complete_reg || $past(complete_reg))
        else $error("blocked result set the flag");
    a_compare_gate: assert property (@(posedge clk_i) disable iff (pwr_reset)
        (conv_done && sc2_reg.compare_enable && !cmp_true) |=> result_reg == $past(result_reg))
        else $error("false compare transferred a result");
    a_flag_on_done: assert property (@(posedge clk_i) disable iff (pwr_reset)
        transfer |=> complete_reg)
        else $error("completion flag missing");
    a_irq_follows: assert property (@(posedge clk_i) disable iff (pwr_reset)
        (transfer && sc1_reg.completion_irq_enable && !wr_en) |=> ##1 irq_o)
        else $error("interrupt not raised");
    a_single_stops: assert property (@(posedge clk_i) disable iff (pwr_reset)
        (conv_done && !sc1_reg.continuous_enable && !blocked_reg) |=> !pending_reg)
        else $error("single conversion restarted");
    a_stop12_clear: assert property (@(posedge clk_i)
        stop12_sync |=> (cfg_reg == '0 && result_reg == '0 && state_reg == adclp_pkg::ST_IDLE))
        else $error("stop1/2 did not reset registers");
    a_sc2_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == adclp_pkg::ADDR_STATUS_CONTROL_TWO)
        |-> wb_dat_o[3:0] == 4'h0)
        else $error("control two low bits not zero");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: register, conversion and low-power checks of adclp_control.
// assumes a 10 MHz clock and a wishbone slave that answers one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk_i = 1'h0, rst_i = 1'h1, req = 1'h0, we = 1'h0, trg = 1'h0, s3 = 1'h0, s12 = 1'h0;
    logic [7:0]  adr = 8'h00, r;
    logic [31:0] dat = 32'h0, q;
    logic        ack, err, smp, irq, e;
    logic [4:0]  ch;
    logic [15:0] pin;
    int          n_fail = 0, tests_run = 0, cyc_n = 0;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] x; } adclp_row_type;
    adclp_row_type rows [5] = '{
        '{8'h18, 8'h98, 8'h98},
        '{8'h04, 8'h3C, 8'h30},
        '{8'h1C, 8'h02, 8'h02},
        '{8'h10, 8'h0A, 8'h0A},
        '{8'h14, 8'hBC, 8'hBC}};
    adclp_control i_adclp_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err),
        .hw_trigger_i(trg), .stop3_i(s3), .stop12_i(s12), .analog_result_i(12'hABC),
        .channel_select_o(ch), .pin_io_disable_o(pin), .sample_o(smp), .irq_o(irq));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until ack or err is seen at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= 1'h1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'h1 && err !== 1'h1);
        r = q[7:0];
        e = err;
        req <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic wait_irq;
        for (int k = 0; k < 400 && irq !== 1'h1; k++) @(posedge clk_i);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        bus(1'h0, 8'h00, 8'h00);
        chk(r, 8'h1F);
        foreach (rows[i]) begin
            bus(1'h1, rows[i].a, rows[i].d);
            bus(1'h0, rows[i].a, 8'h00);
            chk(r, rows[i].x);
        end
        chk(pin[7:0], 8'h02);
        bus(1'h1, 8'h24, 8'h55);
        chk({7'h0, e}, 8'h01);
        $display("register test done");
        bus(1'h1, 8'h04, 8'h00);
        bus(1'h1, 8'h18, 8'h04);
        bus(1'h1, 8'h00, 8'h41);
        chk({3'h0, ch}, 8'h01);
        wait_irq();
        chk({7'h0, irq}, 8'h01);
        repeat (60) @(posedge clk_i);
        chk({7'h0, smp}, 8'h00);
        bus(1'h0, 8'h04, 8'h00);
        chk(r, 8'h00);
        bus(1'h0, 8'h08, 8'h00);
        chk(r, 8'h0A);
        bus(1'h0, 8'h0C, 8'h00);
        chk(r, 8'hBC);
        $display("conversion test done");
        bus(1'h1, 8'h00, 8'h01);
        s3 <= 1'h1;
        repeat (100) @(posedge clk_i);
        s3 <= 1'h0;
        repeat (100) @(posedge clk_i);
        bus(1'h0, 8'h00, 8'h00);
        chk(r, 8'h01);
        bus(1'h0, 8'h08, 8'h00);
        chk(r, 8'h0A);
        bus(1'h0, 8'h0C, 8'h00);
        bus(1'h1, 8'h18, 8'h07);
        bus(1'h1, 8'h00, 8'h41);
        s3 <= 1'h1;
        wait_irq();
        chk({7'h0, irq}, 8'h01);
        s3 <= 1'h0;
        $display("stop3 test done");
        s12 <= 1'h1;
        repeat (5) @(posedge clk_i);
        s12 <= 1'h0;
        repeat (3) @(posedge clk_i);
        bus(1'h0, 8'h18, 8'h00);
        chk(r, 8'h00);
        $display("stop12 test done");
        bus(1'h1, 8'h18, 8'h07);
        bus(1'h1, 8'h10, 8'h0B);
        bus(1'h1, 8'h04, 8'h70);
        bus(1'h1, 8'h00, 8'h41);
        repeat (60) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00);
        s3  <= 1'h1;
        trg <= 1'h1;
        repeat (120) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00);
        trg <= 1'h0;
        bus(1'h1, 8'h10, 8'h0A);
        trg <= 1'h1;
        wait_irq();
        chk({7'h0, irq}, 8'h01);
        s3  <= 1'h0;
        trg <= 1'h0;
        bus(1'h0, 8'h08, 8'h00);
        chk(r, 8'h00);
        bus(1'h0, 8'h0C, 8'h00);
        chk(r, 8'hBC);
        $display("trigger test done");
        results();
    end
endmodule
`default_nettype wire
